/* hw/uart_core.sv */
// serial port top: registers, enables, pin hand-over, baud ticks, address detect
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps

// Functional notes
// - transmitter enable low disables transmitter, aborts sending, empties transmit buffer
// - disabled transmitter releases the transmit pin to general use
// - transmitter runs and drives its pin only when both enables are one
// - clearing transmitter enable mid character aborts at once and frees the pin
// - receiver enable low disables receiver, empties receive buffer, frees receive pin
// - receiver runs and owns its pin only when both enables are one
// - clearing receiver enable mid character aborts and resets the receiver
// - speed select one picks high speed divide, zero low speed, with divisor
// - address bit is eighth bit in 8-bit format, ninth in 9-bit format
// - with detection on, address bit one marks an address word
// - each address word raises an interrupt when its mask bit is set
// - with detection on, words with address bit zero are discarded, no interrupt
// - format select gives 8 or 9 bit characters, ninth bits held apart
// - unit enable turns the port on; pins follow the individual enables
// - bit rate is clock over 64(N+1) low speed, 16(N+1) high speed
module uart_core (
   input wire logic clk,
   input wire logic rst,
   input wire uart_pkg::bus_req_t bus,
   output logic [7:0] rdata,
   input wire logic rx_pin,
   output logic rx_pin_owned,
   output logic tx_pin_out,
   output logic tx_pin_oe,
   output logic irq
);
   import uart_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      ctrl_one_t c1;
      serial_control_two_t c2;
      logic [7:0] divisor;
      logic [STS_W-1:0] mask;
      logic [STS_W-1:0] sts;
      logic [7:0] rdata;
      logic [8:0] txbuf;
      logic txbuf_full;
      logic [8:0] rxbuf;
      logic rxbuf_full;
      logic [1:0] pre;
      logic [7:0] div;
      logic tick;
      logic sync1;
      logic sync2;
      logic sync3;
      logic rx_level;
   } core_state_t;

   core_state_t st_r, st_nxt;
   logic tx_run, rx_run, tx_line, tx_busy, tx_done, tx_start;
   logic rx_valid, rx_busy, addr_bit, accept;
   logic [8:0] rx_data;
   logic [1:0] pre_last;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   // -----------------------------------------------------------------
   // enables and pins
   // -----------------------------------------------------------------
   assign tx_run = st_r.c1.serial_unit_enable & st_r.c2.transmitter_enable;
   assign rx_run = st_r.c1.serial_unit_enable & st_r.c2.receiver_enable;
   assign tx_pin_oe = tx_run;
   assign tx_pin_out = tx_run ? tx_line : 1'b1;
   assign rx_pin_owned = rx_run;
   assign rdata = st_r.rdata;
   assign irq = |(st_r.sts & st_r.mask);
   // the shifter takes the waiting word one cycle after it falls idle
   assign tx_start = st_r.txbuf_full & ~tx_busy;
   assign pre_last = st_r.c2.baud_high_speed_select ? PRE_LAST_HIGH : PRE_LAST_LOW;
   assign addr_bit = st_r.c1.nine_bit_format_select ? rx_data[8] : rx_data[7];
   assign accept = ~st_r.c2.address_detect_enable | addr_bit;

   uart_tx u_tx (
      .clk(clk),
      .rst(rst),
      .run(tx_run),
      .tick(st_r.tick),
      .start(tx_start),
      .data(st_r.txbuf),
      .nine(st_r.c1.nine_bit_format_select),
      .line(tx_line),
      .busy(tx_busy),
      .done(tx_done)
   );

   uart_rx u_rx (
      .clk(clk),
      .rst(rst),
      .run(rx_run),
      .tick(st_r.tick),
      .line(st_r.rx_level),
      .nine(st_r.c1.nine_bit_format_select),
      .valid(rx_valid),
      .data(rx_data),
      .busy(rx_busy)
   );

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      ctrl_one_t rv;
      rv = st_r.c1;
      st_nxt = st_r;
      st_nxt.rdata = 8'h00;

      // receive pin filter: a level counts once two later stages agree
      st_nxt.sync1 = rx_pin;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.sync3 = st_r.sync2;
      if (st_r.sync2 == st_r.sync3) begin
         st_nxt.rx_level = st_r.sync3;
      end

      // baud ticks: (pre_last+1)*(N+1) clocks each, sixteen per bit
      st_nxt.tick = 1'b0;
      if (!st_r.c1.serial_unit_enable) begin
         st_nxt.pre = 2'h0;
         st_nxt.div = 8'h00;
      end else if (st_r.pre >= pre_last) begin
         st_nxt.pre = 2'h0;
         // a divisor lowered below the count ends the period at once instead of wrapping
         if (st_r.div >= st_r.divisor) begin
            st_nxt.div = 8'h00;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.div = 8'(st_r.div + 8'h01);
         end
      end else begin
         st_nxt.pre = 2'(st_r.pre + 2'h1);
      end

      // transmit buffer hands its word to the shifter when idle
      if (tx_start) begin
         st_nxt.txbuf_full = 1'b0;
      end

      // register reads; reading status clears it, reading data clears only the receive buffer full flag
      if (bus.re) begin
         rv.received_ninth_bit = st_r.rxbuf[8];
         if (hit(bus.addr, OFF_CTRL_ONE)) begin
            st_nxt.rdata = rv;
         end else if (hit(bus.addr, OFF_CTRL_TWO)) begin
            st_nxt.rdata = st_r.c2;
         end else if (hit(bus.addr, OFF_DIVISOR)) begin
            st_nxt.rdata = st_r.divisor;
         end else if (hit(bus.addr, OFF_DATA)) begin
            st_nxt.rdata = st_r.rxbuf[7:0];
            st_nxt.rxbuf_full = 1'b0;
         end else if (hit(bus.addr, OFF_STATUS)) begin
            st_nxt.rdata = {5'h00, st_r.sts};
            st_nxt.sts = '0;
         end else if (hit(bus.addr, OFF_MASK)) begin
            st_nxt.rdata = {5'h00, st_r.mask};
         end
      end

      // register writes
      if (bus.we) begin
         if (hit(bus.addr, OFF_CTRL_ONE)) begin
            st_nxt.c1 = ctrl_one_t'(bus.wdata);
            st_nxt.c1.rsvd = '0;
            st_nxt.c1.received_ninth_bit = 1'b0;
         end else if (hit(bus.addr, OFF_CTRL_TWO)) begin
            st_nxt.c2 = serial_control_two_t'(bus.wdata);
            st_nxt.c2.rsvd = '0;
         end else if (hit(bus.addr, OFF_DIVISOR)) begin
            st_nxt.divisor = bus.wdata;
         end else if (hit(bus.addr, OFF_DATA) && tx_run) begin
            // a write to a full buffer replaces the waiting word
            st_nxt.txbuf = {st_r.c1.tx_ninth_bit, bus.wdata};
            st_nxt.txbuf_full = 1'b1;
         end else if (hit(bus.addr, OFF_MASK)) begin
            st_nxt.mask = bus.wdata[STS_W-1:0];
         end
      end

      // received words; set wins over the read clear above
      if (rx_valid && rx_run && accept) begin
         st_nxt.rxbuf = rx_data;
         st_nxt.rxbuf_full = 1'b1;
         st_nxt.sts[STS_RX_WORD] = 1'b1;
         if (st_r.c2.address_detect_enable) begin
            st_nxt.sts[STS_ADDR_WORD] = 1'b1;
         end
      end
      if (tx_done) begin
         st_nxt.sts[STS_TX_DONE] = 1'b1;
      end

      // disabled halves lose their buffered words
      if (!tx_run) begin
         st_nxt.txbuf = 9'h000;
         st_nxt.txbuf_full = 1'b0;
      end
      if (!rx_run) begin
         st_nxt.rxbuf = 9'h000;
         st_nxt.rxbuf_full = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         st_r.c1 <= ctrl_one_t'(CTRL_ONE_RST);
         st_r.c2 <= serial_control_two_t'(CTRL_TWO_RST);
         st_r.divisor <= DIVISOR_RST;
         st_r.mask <= MASK_RST;
         st_r.sync1 <= 1'b1;
         st_r.sync2 <= 1'b1;
         st_r.sync3 <= 1'b1;
         st_r.rx_level <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // clocks since the last tick; any write restarts it, as a new setting gives one odd period
   logic [10:0] gap_r;
   logic gap_ok_r;
   logic [10:0] gap_exp;
   assign gap_exp = st_r.c2.baud_high_speed_select ? 11'({3'h0, st_r.divisor} + 11'h001)
                                                   : 11'(({3'h0, st_r.divisor} + 11'h001) << 2);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_r <= 11'h000;
         gap_ok_r <= 1'b0;
      end else if (bus.we || !st_r.c1.serial_unit_enable) begin
         gap_r <= 11'h000;
         gap_ok_r <= 1'b0;
      end else if (st_r.tick) begin
         gap_r <= 11'h001;
         gap_ok_r <= 1'b1;
      end else begin
         gap_r <= 11'(gap_r + 11'h001);
      end
   end

   // a good word leaving the shifter while the receiver runs with address detection on, split by its address bit
   sequence addr_word_seen;
      rx_valid && rx_run && st_r.c2.address_detect_enable && addr_bit;
   endsequence
   sequence data_word_dropped;
      rx_valid && rx_run && st_r.c2.address_detect_enable && !addr_bit;
   endsequence
   sequence masked_addr_word;
      addr_word_seen ##0 st_r.mask[STS_ADDR_WORD];
   endsequence

   tx_buf_flush_a: assert property (!tx_run |=> !st_r.txbuf_full)
      else $error("transmit buffer kept a word while disabled");
   tx_pin_free_a: assert property (!st_r.c2.transmitter_enable |-> !tx_pin_oe)
      else $error("transmit pin driven while transmitter disabled");
   tx_pin_drive_a: assert property (tx_run |-> tx_pin_oe && tx_pin_out == tx_line)
      else $error("transmit pin not driven by shifter when enabled");
   tx_abort_a: assert property (tx_busy && !tx_run |=> !tx_busy && tx_pin_out)
      else $error("transmission not aborted on disable");
   rx_abort_a: assert property (rx_busy && !rx_run |=> !rx_busy ##1 !rx_valid)
      else $error("reception not aborted on disable");
   rx_buf_flush_a: assert property (!rx_run |=> !st_r.rxbuf_full)
      else $error("receive buffer held while disabled");
   rx_pin_free_a: assert property (!rx_run |-> !rx_pin_owned)
      else $error("receive pin held while disabled");
   baud_period_a: assert property (st_r.tick && gap_ok_r |-> gap_r == gap_exp)
      else $error("baud tick spacing wrong");
   addr_flag_a: assert property (addr_word_seen |=> st_r.sts[STS_ADDR_WORD])
      else $error("address word not flagged");
   addr_irq_a: assert property (masked_addr_word |=> irq)
      else $error("address word raised no interrupt");
   addr_drop_a: assert property (data_word_dropped |=> st_r.rxbuf == $past(st_r.rxbuf))
      else $error("data word stored under address detection");
   ninth_keep_a: assert property (rx_valid && rx_run && !st_r.c2.address_detect_enable
                                  |=> st_r.rxbuf == $past(rx_data))
      else $error("received word not stored whole");
   pins_off_a: assert property (!st_r.c1.serial_unit_enable |-> !tx_pin_oe && !rx_pin_owned)
      else $error("pin held while serial unit disabled");
   rx_gate_a: assert property (!rx_run |=> !rx_busy)
      else $error("receiver busy while not enabled");
   tx_ninth_a: assert property (bus.we && hit(bus.addr, OFF_DATA) && tx_run |=>
                                st_r.txbuf[8] == $past(st_r.c1.tx_ninth_bit))
      else $error("ninth transmit bit not taken with the word");
   drop_quiet_a: assert property (data_word_dropped ##0 !bus.re |=>
                                  st_r.sts[1:0] == $past(st_r.sts[1:0]))
      else $error("discarded word set a receive status bit");

endmodule : uart_core

/* hw/uart_pkg.sv */
// constants, register map and carrier types of the serial port block
package uart_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int ADDR_W = 3;
   localparam logic [2:0] OFF_CTRL_ONE = 3'h0;
   localparam logic [2:0] OFF_CTRL_TWO = 3'h1;
   localparam logic [2:0] OFF_DIVISOR = 3'h2;
   localparam logic [2:0] OFF_DATA = 3'h3;
   localparam logic [2:0] OFF_STATUS = 3'h4;
   localparam logic [2:0] OFF_MASK = 3'h5;

   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] CTRL_TWO_RST = 8'h00;
   localparam logic [7:0] DIVISOR_RST = 8'h00;
   localparam logic [2:0] MASK_RST = 3'h0;

   // event bits of the status and mask registers
   localparam int STS_W = 3;
   localparam int STS_RX_WORD = 0;
   localparam int STS_ADDR_WORD = 1;
   localparam int STS_TX_DONE = 2;

   // -----------------------------------------------------------------
   // baud timing: a tick is one sixteenth of a bit
   // -----------------------------------------------------------------
   localparam logic [1:0] PRE_LAST_LOW = 2'h3;
   localparam logic [1:0] PRE_LAST_HIGH = 2'h0;
   localparam logic [3:0] OS_LAST = 4'hF;
   localparam logic [3:0] OS_MID = 4'h7;
   localparam logic [3:0] LAST_BIT_EIGHT = 4'h9;
   localparam logic [3:0] LAST_BIT_NINE = 4'hA;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic serial_unit_enable;
      logic nine_bit_format_select;
      logic [3:0] rsvd;
      logic received_ninth_bit;
      logic tx_ninth_bit;
   } ctrl_one_t;

   typedef struct packed {
      logic transmitter_enable;
      logic receiver_enable;
      logic baud_high_speed_select;
      logic address_detect_enable;
      logic [3:0] rsvd;
   } serial_control_two_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } bus_req_t;

endpackage : uart_pkg

/* hw/uart_tx.sv */
// transmit shifter: start bit, 8 or 9 data bits lsb first, one stop bit
`timescale 1ns/1ps
module uart_tx (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic tick,
   input wire logic start,
   input wire logic [8:0] data,
   input wire logic nine,
   output logic line,
   output logic busy,
   output logic done
);
   import uart_pkg::*;

   typedef struct packed {
      logic busy;
      logic [3:0] os;
      logic [3:0] bitn;
      logic [10:0] shreg;
      logic line;
      logic done;
   } tx_state_t;

   tx_state_t st_r, st_nxt;
   logic [10:0] frame;
   logic [3:0] last_bit;

   always_comb begin
      frame = {1'b1, nine ? data[8] : 1'b1, data[7:0], 1'b0};
      last_bit = nine ? LAST_BIT_NINE : LAST_BIT_EIGHT;
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (!run) begin
         // disable drops the frame at once, mid bit or not
         st_nxt = '0;
         st_nxt.line = 1'b1;
      end else if (!st_r.busy) begin
         if (start) begin
            st_nxt.busy = 1'b1;
            st_nxt.os = 4'h0;
            st_nxt.bitn = 4'h0;
            st_nxt.line = frame[0];
            st_nxt.shreg = {1'b1, frame[10:1]};
         end
      end else if (tick) begin
         if (st_r.os == OS_LAST) begin
            st_nxt.os = 4'h0;
            if (st_r.bitn == last_bit) begin
               st_nxt.busy = 1'b0;
               st_nxt.done = 1'b1;
               st_nxt.line = 1'b1;
            end else begin
               st_nxt.bitn = 4'(st_r.bitn + 4'h1);
               st_nxt.line = st_r.shreg[0];
               st_nxt.shreg = {1'b1, st_r.shreg[10:1]};
            end
         end else begin
            st_nxt.os = 4'(st_r.os + 4'h1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '{busy: 1'b0, os: 4'h0, bitn: 4'h0, shreg: 11'h7FF, line: 1'b1, done: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign line = st_r.line;
   assign busy = st_r.busy;
   assign done = st_r.done;

endmodule : uart_tx

/* hw/uart_rx.sv */
// receive shifter: mid-bit sampling on the sixteen-tick grid
`timescale 1ns/1ps
module uart_rx (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic tick,
   input wire logic line,
   input wire logic nine,
   output logic valid,
   output logic [8:0] data,
   output logic busy
);
   import uart_pkg::*;

   typedef struct packed {
      logic busy;
      logic [3:0] os;
      logic [3:0] bitn;
      logic [8:0] shreg;
      logic prev;
      logic valid;
      logic [8:0] data;
   } rx_state_t;

   rx_state_t st_r, st_nxt;
   logic [3:0] last_bit;

   always_comb begin
      last_bit = nine ? LAST_BIT_NINE : LAST_BIT_EIGHT;
      st_nxt = st_r;
      st_nxt.valid = 1'b0;
      st_nxt.prev = line;
      if (!run) begin
         st_nxt = '0;
         st_nxt.prev = 1'b1;
      end else if (!st_r.busy) begin
         if (st_r.prev && !line) begin
            st_nxt.busy = 1'b1;
            st_nxt.os = 4'h0;
            st_nxt.bitn = 4'h0;
         end
      end else if (tick) begin
         st_nxt.os = 4'(st_r.os + 4'h1);
         if (st_r.bitn == 4'h0) begin
            if (st_r.os == OS_MID) begin
               // a glitch that is high again at mid start bit is no frame
               st_nxt.busy = !line;
               st_nxt.os = 4'h0;
               st_nxt.bitn = 4'h1;
            end
         end else if (st_r.os == OS_LAST) begin
            st_nxt.os = 4'h0;
            if (st_r.bitn == last_bit) begin
               // a word with a low stop bit is dropped
               st_nxt.busy = 1'b0;
               st_nxt.valid = line;
               st_nxt.data = nine ? st_r.shreg : {1'b0, st_r.shreg[8:1]};
            end else begin
               st_nxt.bitn = 4'(st_r.bitn + 4'h1);
               st_nxt.shreg = {line, st_r.shreg[8:1]};
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '{busy: 1'b0, os: 4'h0, bitn: 4'h0, shreg: 9'h000, prev: 1'b1,
                   valid: 1'b0, data: 9'h000};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign valid = st_r.valid;
   assign data = st_r.data;
   assign busy = st_r.busy;

endmodule : uart_rx

/* verif/serial_node.sv */
// behavioural remote serial node on the far side of the receive and transmit pins
`timescale 1ns/1ps
module serial_node (
   input wire logic clk,
   input wire logic tx_line,
   input wire logic tx_oe,
   output logic rx_line
);
   int bit_clks = 16;
   logic seen;

   // a released transmit pin floats up through its pull-up
   assign seen = tx_oe ? tx_line : 1'b1;

   initial rx_line = 1'b1;

   // ---------------------------------------------------------------
   // frames: start bit, data lsb first, one stop bit, then idle high
   // ---------------------------------------------------------------
   task automatic send(input logic [8:0] w, input bit nine);
      logic [10:0] f;
      int n;
      n = nine ? 11 : 10;
      f = nine ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
      @(posedge clk);
      for (int i = 0; i < n; i++) begin
         rx_line <= f[i];
         repeat (bit_clks) @(posedge clk);
      end
   endtask : send

   // samples each bit in its middle; gives unknowns if no frame comes
   task automatic grab(output logic [8:0] w, input bit nine);
      int t;
      w = 'x;
      t = 0;
      while (seen !== 1'b0 && t < 4000) begin
         @(posedge clk);
         t++;
      end
      if (t < 4000) begin
         w = '0;
         repeat (bit_clks / 2) @(posedge clk);
         for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (bit_clks) @(posedge clk);
            w[i] = seen;
         end
      end
   endtask : grab
endmodule : serial_node

/* verif/tb.sv */
// self-checking bench of the serial port block
`timescale 1ns/1ps
module tb;
   import uart_pkg::*;

   typedef struct {logic [7:0] c1; logic [7:0] c2; logic own; logic oe;} pin_row_t;
   typedef struct {logic [7:0] c1; logic [7:0] c2; logic [8:0] w; logic [7:0] st;} rx_row_t;

   logic clk;
   logic rst;
   bus_req_t bus;
   logic [7:0] rdata;
   logic rx_pin;
   logic rx_pin_owned;
   logic tx_pin_out;
   logic tx_pin_oe;
   logic irq;
   int errors = 0;
   int check_count = 0;
   logic [7:0] v;
   logic [8:0] w;
   int k;

   pin_row_t pins[6] = '{'{8'h00, 8'hC0, 0, 0}, '{8'h80, 8'h00, 0, 0}, '{8'h80, 8'h80, 0, 1},
      '{8'h80, 8'h40, 1, 0}, '{8'h80, 8'hFF, 1, 1}, '{8'h00, 8'hF0, 0, 0}};
   // mask watches address words only, so irq follows status bit 1
   rx_row_t rxs[5] = '{'{8'h80, 8'hE0, 9'h03C, 8'h01}, '{8'h80, 8'hF0, 9'h080, 8'h03},
      '{8'h80, 8'hF0, 9'h07F, 8'h00}, '{8'hC0, 8'hF0, 9'h101, 8'h03},
      '{8'hC0, 8'hF0, 9'h0FF, 8'h00}};

   uart_core dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .rx_pin(rx_pin),
      .rx_pin_owned(rx_pin_owned), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .irq(irq));

   serial_node node (.clk(clk), .tx_line(tx_pin_out), .tx_oe(tx_pin_oe), .rx_line(rx_pin));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // bus cycles and comparison
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk);
      bus.we <= 1'b0;
   endtask : wr

   task automatic rdchk(input string nm, input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge clk);
      bus.re <= 1'b0;
      #1 chk(nm, rdata, e);
   endtask : rdchk

   // length of bit 0 of the frame of 0x01; the start bit may be cut by the free prescaler
   task automatic bit_len(input logic [7:0] c2, input logic [7:0] n, input int e);
      wr(OFF_DIVISOR, n);
      wr(OFF_CTRL_TWO, c2);
      wr(OFF_DATA, 8'h01);
      k = 0;
      while (tx_pin_out !== 1'b0 && k < 600) begin
         @(posedge clk);
         k++;
      end
      while (tx_pin_out !== 1'b1 && k < 600) begin
         @(posedge clk);
         k++;
      end
      k = 0;
      while (tx_pin_out === 1'b1 && k < 600) begin
         @(posedge clk);
         k++;
      end
      chk("bit_len", k[15:0], e[15:0]);
      repeat (10 * e) @(posedge clk);
   endtask : bit_len

   task automatic tally_and_finish();
      if (errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #400000;
      errors++;
      tally_and_finish();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1;
      bus = '0;
      repeat (16) @(posedge clk);
      chk("oe_rst", tx_pin_oe, 0);
      chk("line_rst", tx_pin_out, 1);
      chk("owned_rst", rx_pin_owned, 0);
      chk("irq_rst", irq, 0);
      rst <= 1'b0;
      rdchk("ctrl_two_rst", OFF_CTRL_TWO, CTRL_TWO_RST);
      rdchk("mask_rst", OFF_MASK, {5'h00, MASK_RST});
      wr(3'h6, 8'hFF);
      rdchk("unmapped", 3'h6, 8'h00);
      foreach (pins[i]) begin
         wr(OFF_CTRL_ONE, pins[i].c1);
         wr(OFF_CTRL_TWO, pins[i].c2);
         rdchk("ctrl_two", OFF_CTRL_TWO, pins[i].c2 & 8'hF0);
         chk("rx_owned", rx_pin_owned, pins[i].own);
         chk("tx_oe", tx_pin_oe, pins[i].oe);
         chk("tx_idle", tx_pin_out, 1);
      end
      // transmit in both formats, with the done event on the interrupt checked after the 8-bit word
      wr(OFF_CTRL_ONE, 8'h80);
      wr(OFF_CTRL_TWO, 8'hE0);
      wr(OFF_MASK, 8'h04);
      rdchk("status_clr", OFF_STATUS, 8'h00);
      fork
         node.grab(w, 1'b0);
         wr(OFF_DATA, 8'hA5);
      join
      chk("tx_word8", w, 9'h0A5);
      repeat (32) @(posedge clk);
      chk("irq_done", irq, 1);
      rdchk("status_done", OFF_STATUS, 8'h04);
      chk("irq_clr", irq, 0);
      wr(OFF_CTRL_ONE, 8'hC1);
      fork
         node.grab(w, 1'b1);
         wr(OFF_DATA, 8'h3C);
      join
      chk("tx_word9", w, 9'h13C);
      repeat (32) @(posedge clk);
      wr(OFF_CTRL_ONE, 8'h80);
      bit_len(8'h80, 8'h00, 64);
      bit_len(8'hA0, 8'h01, 32);
      bit_len(8'hA0, 8'h02, 48);
      bit_len(8'h80, 8'h01, 128);
      // abort in mid character; nothing may be resent after re-enabling
      wr(OFF_DIVISOR, 8'h00);
      wr(OFF_CTRL_TWO, 8'hE0);
      wr(OFF_DATA, 8'h00);
      repeat (40) @(posedge clk);
      wr(OFF_CTRL_TWO, 8'h60);
      @(posedge clk);
      #1 chk("abort_oe", tx_pin_oe, 0);
      chk("abort_line", tx_pin_out, 1);
      wr(OFF_CTRL_TWO, 8'hE0);
      k = 0;
      repeat (200) begin
         @(posedge clk);
         k += (tx_pin_out === 1'b0);
      end
      chk("no_resend", k[15:0], 0);
      // receive, plain and with address detection
      wr(OFF_MASK, 8'h02);
      // the frames of the bit length runs have left their done event pending
      rdchk("status_clr2", OFF_STATUS, 8'h04);
      foreach (rxs[i]) begin
         wr(OFF_CTRL_ONE, rxs[i].c1);
         wr(OFF_CTRL_TWO, rxs[i].c2);
         node.send(rxs[i].w, rxs[i].c1[6]);
         repeat (6) @(posedge clk);
         chk("irq_word", irq, rxs[i].st[1]);
         rdchk("status_word", OFF_STATUS, rxs[i].st);
         if (rxs[i].st != 8'h00) begin
            rdchk("ninth_bit", OFF_CTRL_ONE, rxs[i].c1 | {6'h00, rxs[i].w[8], 1'b0});
            rdchk("rx_data", OFF_DATA, rxs[i].w[7:0]);
         end
      end
      // drop the receiver during the low data bits, back on while the line is high
      wr(OFF_CTRL_ONE, 8'h80);
      wr(OFF_CTRL_TWO, 8'hE0);
      fork
         node.send(9'h0F0, 1'b0);
         begin
            repeat (36) @(posedge clk);
            wr(OFF_CTRL_TWO, 8'hA0);
            #1 chk("rx_freed", rx_pin_owned, 0);
            repeat (50) @(posedge clk);
            wr(OFF_CTRL_TWO, 8'hE0);
         end
      join
      repeat (20) @(posedge clk);
      rdchk("status_abort", OFF_STATUS, 8'h00);
      rdchk("rx_cleared", OFF_DATA, 8'h00);
      tally_and_finish();
   end
endmodule : tb
